// ==== swfl_defines.svh ====
/*
 * Constants of the status word and flag logic: status bit positions,
 * the writable mask of the upper byte, reset values and sizes.
 * Assumes it is included by its bare name from the block's files only.
 */
`ifndef SWFL_DEFINES_SVH
`define SWFL_DEFINES_SVH

// ***************************************************
// status upper byte layout
// ***************************************************
`define SWFL_SU_SENSE 7
`define SWFL_SU_FLAG 6
`define SWFL_SU_IBLOCK 5
`define SWFL_SU_PTR_HI 2
`define SWFL_SU_PTR_LO 0
// bits that software may change; sense and the unused bits 4..3 are not among them
`define SWFL_SU_WRITABLE 8'h67
`define SWFL_SU_RESET 8'h00

// ***************************************************
// status lower byte layout
// ***************************************************
`define SWFL_SL_CC_HI 7
`define SWFL_SL_CC_LO 6
`define SWFL_SL_NIB 5
`define SWFL_SL_BANK 4
`define SWFL_SL_WITHC 3
`define SWFL_SL_OVF 2
`define SWFL_SL_UCMP 1
`define SWFL_SL_CARRY 0
`define SWFL_SL_RESET 8'h00

// ***************************************************
// condition field codes and sizes
// ***************************************************
`define SWFL_CC_POS 2'h1
`define SWFL_CC_ZERO 2'h0
`define SWFL_CC_NEG 2'h2
`define SWFL_STACK_DEPTH 8
`define SWFL_ADDR_W 15
`define SWFL_GPR_COUNT 7
`define SWFL_BANK_SIZE 3

`endif

// ==== swfl_pkg.sv ====
/*
 * Types shared by the status word and flag logic.
 * Assumes the instruction decoder drives one operation per clock.
 */
package swfl_pkg;

    typedef logic [7:0] swfl_byte_t;

    // one decoded operation per cycle
    typedef enum logic [4:0] {
        SWFL_OP_NOP,
        SWFL_OP_LOAD,
        SWFL_OP_ADD,
        SWFL_OP_SUB,
        SWFL_OP_AND,
        SWFL_OP_IOR,
        SWFL_OP_EOR,
        SWFL_OP_CMP,
        SWFL_OP_ROL,
        SWFL_OP_ROR,
        SWFL_OP_TEST,
        SWFL_OP_LDSU,
        SWFL_OP_LDSL,
        SWFL_OP_PRSU,
        SWFL_OP_PRSL,
        SWFL_OP_CLSU,
        SWFL_OP_CLSL,
        SWFL_OP_STSU,
        SWFL_OP_STSL,
        SWFL_OP_TSSU,
        SWFL_OP_TSSL,
        SWFL_OP_CALL,
        SWFL_OP_RET,
        SWFL_OP_RET_EN,
        SWFL_OP_BRANCH
    } swfl_op_e;

    typedef enum logic [1:0] {
        SWFL_ALU_ADD,
        SWFL_ALU_SUB,
        SWFL_ALU_ROL,
        SWFL_ALU_ROR
    } swfl_alu_mode_e;

endpackage

// ==== swfl_alu_if.sv ====
/*
 * Carrier between the main status logic and its adder/rotator.
 * Assumes both ends sit on the same clock; the path is combinational.
 */
`timescale 1ns/1ps

interface swfl_alu_if;
    import swfl_pkg::*;
    swfl_byte_t a;
    swfl_byte_t b;
    swfl_alu_mode_e mode;
    logic with_carry;
    logic carry_in;
    swfl_byte_t result;
    logic carry_out;
    logic ovf_out;
    logic nib_out;

    modport alu (
        input a, b, mode, with_carry, carry_in,
        output result, carry_out, ovf_out, nib_out
    );
    modport user (
        output a, b, mode, with_carry, carry_in,
        input result, carry_out, ovf_out, nib_out
    );
endinterface

// ==== swfl_alu.sv ====
/*
 * Adder, subtractor and rotator with carry, overflow and nibble carry.
 * Assumes the caller decides which flags to keep for each operation.
 */
`timescale 1ns/1ps

module swfl_alu (
    swfl_alu_if.alu port
);
    import swfl_pkg::*;

    // ***************************************************
    // add and subtract
    // ***************************************************
    wire is_sub = (port.mode == SWFL_ALU_SUB);
    wire [7:0] b_eff = is_sub ? ~port.b : port.b;
    // without carry a subtract gets its own "no borrow" input; with carry,
    // a stored carry of 1 means no borrow
    wire cin_eff = port.with_carry ? port.carry_in : is_sub;
    wire [4:0] low_sum = {1'b0, port.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    wire [8:0] full_sum = {1'b0, port.a} + {1'b0, b_eff} + {8'h00, cin_eff};
    wire sum_ovf = is_sub
        ? (port.a[7] != port.b[7]) && (full_sum[7] != port.a[7])
        : (port.a[7] == port.b[7]) && (full_sum[7] != port.a[7]);

    // ***************************************************
    // rotates, nine bits wide when carry takes part
    // ***************************************************
    wire rot_left = (port.mode == SWFL_ALU_ROL);
    wire fill_left = port.with_carry ? port.carry_in : port.a[7];
    wire fill_right = port.with_carry ? port.carry_in : port.a[0];
    wire [7:0] rot_res = rot_left ? {port.a[6:0], fill_left} : {fill_right, port.a[7:1]};
    wire rot_carry = rot_left ? port.a[7] : port.a[0];

    always_comb begin
        if (port.mode == SWFL_ALU_ADD || is_sub) begin
            port.result = full_sum[7:0];
            port.carry_out = full_sum[8];
            port.ovf_out = sum_ovf;
            port.nib_out = low_sum[4];
        end else begin
            port.result = rot_res;
            port.carry_out = rot_carry;
            port.ovf_out = ~port.a[7] & rot_res[7];
            port.nib_out = rot_res[5];
        end
    end
endmodule

// ==== swfl_ret_stack.sv ====
/*
 * Return address storage: a small flip-flop array, written and read by index.
 * Assumes the owner keeps the level pointer and wraps it.
 */
`timescale 1ns/1ps

module swfl_ret_stack #(
    parameter int DEPTH = 8,
    parameter int ADDR_W = 15
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic write_in,
    input wire logic [$clog2(DEPTH)-1:0] write_level_in,
    input wire logic [ADDR_W-1:0] write_data_in,
    input wire logic [$clog2(DEPTH)-1:0] read_level_in,
    output logic [ADDR_W-1:0] read_data_out
);
    // the pointer wraps by plain overflow, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("swfl_ret_stack: DEPTH must be a power of two");
    end

    logic [ADDR_W-1:0] level_reg [DEPTH];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                level_reg[i] <= '0;
            end
        end else if (write_in) begin
            level_reg[write_level_in] <= write_data_in;
        end
    end

    assign read_data_out = level_reg[read_level_in];
endmodule

// ==== swfl_core.sv ====
/*
 * Status control word, flag logic, general registers and return stack
 * of an 8-bit processor.
 * Assumes one decoded operation per clock from the instruction decoder,
 * and raw asynchronous sense and interrupt request pins.
 */
`timescale 1ns/1ps
`include "swfl_defines.svh"

module swfl_core #(
    parameter int STACK_DEPTH = `SWFL_STACK_DEPTH,
    parameter int ADDR_W = `SWFL_ADDR_W
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input swfl_pkg::swfl_op_e op_in,
    input wire logic [1:0] reg_num_in,
    input wire logic reg_to_reg_in,
    input wire logic [7:0] operand_in,
    input wire logic [ADDR_W-1:0] target_in,
    input wire logic [ADDR_W-1:0] return_addr_in,
    input wire logic fetch_step_in,
    input wire logic int_taken_in,
    input wire logic sense_pin_in,
    input wire logic int_req_n_in,
    output logic flag_out,
    output logic int_pending_out,
    output logic [7:0] status_upper_out,
    output logic [7:0] status_lower_out,
    output logic [7:0] reg_data_out,
    output logic [ADDR_W-1:0] next_fetch_pointer_out
);
    import swfl_pkg::*;

    localparam int PTR_W = $clog2(STACK_DEPTH);

    if (STACK_DEPTH != `SWFL_STACK_DEPTH || ADDR_W < 1) begin : g_bad_depth
        $error("swfl_core: pointer field holds exactly eight levels");
    end

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic sense_meta_reg;
    logic sense_sync_reg;
    logic req_meta_reg;
    logic req_sync_reg;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sense_meta_reg <= 1'b0;
            sense_sync_reg <= 1'b0;
            req_meta_reg <= 1'b1;
            req_sync_reg <= 1'b1;
        end else begin
            sense_meta_reg <= sense_pin_in;
            sense_sync_reg <= sense_meta_reg;
            req_meta_reg <= int_req_n_in;
            req_sync_reg <= req_meta_reg;
        end
    end

    // ***************************************************
    // state
    // ***************************************************
    logic [7:0] su_reg;
    logic [7:0] su_next;
    logic [7:0] sl_reg;
    logic [7:0] sl_next;
    logic [7:0] gpr_reg [`SWFL_GPR_COUNT];
    logic [ADDR_W-1:0] fetch_reg;
    logic [ADDR_W-1:0] fetch_next;
    logic pending_reg;
    logic [7:0] data_out_reg;

    // ***************************************************
    // register bank selection
    // ***************************************************
    wire bank_sel = sl_reg[`SWFL_SL_BANK];
    wire [2:0] bank_base = bank_sel ? 3'(`SWFL_BANK_SIZE) : 3'h0;
    // register zero sits outside the banks and is always index 0
    wire [2:0] x_index = (reg_num_in == 2'h0) ? 3'h0 : 3'(reg_num_in) + bank_base;
    wire [2:0] dest_index = reg_to_reg_in ? 3'h0 : x_index;
    wire [7:0] reg_x = gpr_reg[x_index];
    wire [7:0] reg_zero = gpr_reg[0];
    // reg-to-reg forms work on register zero with register x as source
    wire [7:0] first_opd = reg_to_reg_in ? reg_zero : reg_x;
    wire [7:0] second_opd = reg_to_reg_in ? reg_x : operand_in;

    // ***************************************************
    // adder and rotator
    // ***************************************************
    swfl_alu_if alu_bus ();

    assign alu_bus.a = first_opd;
    assign alu_bus.b = second_opd;
    assign alu_bus.with_carry = sl_reg[`SWFL_SL_WITHC];
    assign alu_bus.carry_in = sl_reg[`SWFL_SL_CARRY];
    assign alu_bus.mode = (op_in == SWFL_OP_SUB) ? SWFL_ALU_SUB :
                          (op_in == SWFL_OP_ROL) ? SWFL_ALU_ROL :
                          (op_in == SWFL_OP_ROR) ? SWFL_ALU_ROR : SWFL_ALU_ADD;

    swfl_alu u_alu (
        .port(alu_bus)
    );

    // ***************************************************
    // compare and test
    // ***************************************************
    wire cmp_unsigned = sl_reg[`SWFL_SL_UCMP];
    wire cmp_gt = cmp_unsigned ? (first_opd > second_opd)
                               : ($signed(first_opd) > $signed(second_opd));
    wire cmp_eq = (first_opd == second_opd);
    wire [1:0] cmp_cc = cmp_eq ? `SWFL_CC_ZERO : (cmp_gt ? `SWFL_CC_POS : `SWFL_CC_NEG);
    wire [7:0] su_view = {sense_sync_reg, su_reg[6:0]};
    wire [7:0] test_src = (op_in == SWFL_OP_TSSU) ? su_view :
                          (op_in == SWFL_OP_TSSL) ? sl_reg : reg_x;
    // all ones under the mask gives zero code, never 11
    wire [1:0] test_cc = ((test_src & operand_in) == operand_in) ? `SWFL_CC_ZERO
                                                                : `SWFL_CC_NEG;

    // ***************************************************
    // register write data
    // ***************************************************
    logic [7:0] wr_data;
    logic wr_en;

    always_comb begin
        wr_en = 1'b1;
        case (op_in)
            SWFL_OP_LOAD: wr_data = second_opd;
            SWFL_OP_ADD, SWFL_OP_SUB, SWFL_OP_ROL, SWFL_OP_ROR: wr_data = alu_bus.result;
            SWFL_OP_AND: wr_data = first_opd & second_opd;
            SWFL_OP_IOR: wr_data = first_opd | second_opd;
            SWFL_OP_EOR: wr_data = first_opd ^ second_opd;
            SWFL_OP_STSU: wr_data = su_view;
            SWFL_OP_STSL: wr_data = sl_reg;
            default: begin
                wr_data = 8'h00;
                wr_en = 1'b0;
            end
        endcase
    end

    wire stsx_op = (op_in == SWFL_OP_STSU) || (op_in == SWFL_OP_STSL);
    wire [2:0] wr_index = stsx_op ? 3'h0 : dest_index;
    wire [1:0] data_cc = (wr_data == 8'h00) ? `SWFL_CC_ZERO :
                         (wr_data[7] ? `SWFL_CC_NEG : `SWFL_CC_POS);

    // ***************************************************
    // return stack and level pointer
    // ***************************************************
    wire [PTR_W-1:0] level_ptr = su_reg[`SWFL_SU_PTR_HI:`SWFL_SU_PTR_LO];
    wire do_call = (op_in == SWFL_OP_CALL);
    wire do_ret = (op_in == SWFL_OP_RET) || (op_in == SWFL_OP_RET_EN);
    wire [PTR_W-1:0] level_up = level_ptr + PTR_W'(1);
    wire [PTR_W-1:0] level_down = level_ptr - PTR_W'(1);
    wire [ADDR_W-1:0] stack_top;

    swfl_ret_stack #(
        .DEPTH(STACK_DEPTH),
        .ADDR_W(ADDR_W)
    ) u_stack (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .write_in(do_call),
        .write_level_in(level_up),
        .write_data_in(return_addr_in),
        .read_level_in(level_ptr),
        .read_data_out(stack_top)
    );

    // ***************************************************
    // interrupt acceptance
    // ***************************************************
    // a request is taken only while the block bit is clear
    wire int_accept = ~req_sync_reg & ~su_reg[`SWFL_SU_IBLOCK] & ~pending_reg;

    // ***************************************************
    // status next values
    // ***************************************************
    always_comb begin
        su_next = su_reg;
        sl_next = sl_reg;
        case (op_in)
            SWFL_OP_LDSU: su_next = (su_reg & ~`SWFL_SU_WRITABLE)
                                  | (reg_zero & `SWFL_SU_WRITABLE);
            SWFL_OP_PRSU: su_next = su_reg | (operand_in & `SWFL_SU_WRITABLE);
            SWFL_OP_CLSU: su_next = su_reg & ~(operand_in & `SWFL_SU_WRITABLE);
            SWFL_OP_LDSL: sl_next = reg_zero;
            SWFL_OP_PRSL: sl_next = sl_reg | operand_in;
            SWFL_OP_CLSL: sl_next = sl_reg & ~operand_in;
            SWFL_OP_CMP: sl_next[`SWFL_SL_CC_HI:`SWFL_SL_CC_LO] = cmp_cc;
            SWFL_OP_TEST, SWFL_OP_TSSU, SWFL_OP_TSSL: begin
                sl_next[`SWFL_SL_CC_HI:`SWFL_SL_CC_LO] = test_cc;
            end
            SWFL_OP_CALL: su_next[`SWFL_SU_PTR_HI:`SWFL_SU_PTR_LO] = level_up;
            SWFL_OP_RET, SWFL_OP_RET_EN: begin
                su_next[`SWFL_SU_PTR_HI:`SWFL_SU_PTR_LO] = level_down;
            end
            default: begin
                su_next = su_reg;
            end
        endcase
        if (wr_en) begin
            sl_next[`SWFL_SL_CC_HI:`SWFL_SL_CC_LO] = data_cc;
        end
        if (op_in == SWFL_OP_ADD || op_in == SWFL_OP_SUB ||
            ((op_in == SWFL_OP_ROL || op_in == SWFL_OP_ROR) && sl_reg[`SWFL_SL_WITHC])) begin
            sl_next[`SWFL_SL_CARRY] = alu_bus.carry_out;
            sl_next[`SWFL_SL_OVF] = alu_bus.ovf_out;
            sl_next[`SWFL_SL_NIB] = alu_bus.nib_out;
        end
        if (op_in == SWFL_OP_RET_EN) begin
            su_next[`SWFL_SU_IBLOCK] = 1'b0;
        end
        // acceptance wins over a clear in the same cycle
        if (int_accept) begin
            su_next[`SWFL_SU_IBLOCK] = 1'b1;
        end
        su_next[`SWFL_SU_SENSE] = 1'b0;
        su_next[4:3] = 2'h0;
    end

    // ***************************************************
    // fetch pointer next value
    // ***************************************************
    always_comb begin
        if (do_ret) begin
            fetch_next = stack_top;
        end else if (do_call || op_in == SWFL_OP_BRANCH) begin
            fetch_next = target_in;
        end else if (fetch_step_in) begin
            fetch_next = fetch_reg + ADDR_W'(1);
        end else begin
            fetch_next = fetch_reg;
        end
    end

    // ***************************************************
    // registers
    // ***************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            su_reg <= `SWFL_SU_RESET;
            sl_reg <= `SWFL_SL_RESET;
            fetch_reg <= '0;
            pending_reg <= 1'b0;
        end else begin
            su_reg <= su_next;
            sl_reg <= sl_next;
            fetch_reg <= fetch_next;
            pending_reg <= int_accept | (pending_reg & ~int_taken_in);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < `SWFL_GPR_COUNT; i++) begin
                gpr_reg[i] <= 8'h00;
            end
            data_out_reg <= 8'h00;
        end else begin
            if (wr_en) begin
                gpr_reg[wr_index] <= wr_data;
            end
            data_out_reg <= reg_x;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    assign flag_out = su_reg[`SWFL_SU_FLAG];
    assign int_pending_out = pending_reg;
    assign status_upper_out = su_view;
    assign status_lower_out = sl_reg;
    assign reg_data_out = data_out_reg;
    assign next_fetch_pointer_out = fetch_reg;
endmodule

// ==== swfl_core_monitor.sv ====
/*
 * Checker for the status word, flag and return stack logic of swfl_core.
 * Assumes it is bound to swfl_core and sees only that module's ports.
 */
`timescale 1ns/1ps

module swfl_core_monitor
    import swfl_pkg::*;
#(
    parameter int ADDR_W = 15
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire swfl_pkg::swfl_op_e op_in,
    input wire logic reg_to_reg_in,
    input wire logic [7:0] operand_in,
    input wire logic [ADDR_W-1:0] target_in,
    input wire logic [ADDR_W-1:0] return_addr_in,
    input wire logic sense_pin_in,
    input wire logic int_pending_out,
    input wire logic [7:0] status_upper_out,
    input wire logic [7:0] status_lower_out,
    input wire logic [ADDR_W-1:0] next_fetch_pointer_out
);
    // ***************************************************
    // relations between operations and status
    // ***************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    AST_CC_NEVER_11: assert property (($past(op_in) != SWFL_OP_LDSL) &&
        ($past(op_in) != SWFL_OP_PRSL) && ($past(status_lower_out[7:6]) != 2'h3)
        |-> status_lower_out[7:6] != 2'h3) else $error("condition 11 from normal op");
    AST_SENSE_HI: assert property (sense_pin_in [*4] |=> status_upper_out[7])
        else $error("sense bit not following pin");
    AST_IBLOCK_SET: assert property ($rose(int_pending_out) |->
        status_upper_out[5] && !$past(status_upper_out[5])) else $error("accept while blocked");
    AST_RET_EN_CLEAR: assert property (($past(op_in) == SWFL_OP_RET_EN) &&
        !$rose(int_pending_out) |-> !status_upper_out[5]) else $error("block bit kept");
    AST_CALL_PTR: assert property ($past(op_in) == SWFL_OP_CALL |->
        (status_upper_out[2:0] == $past(status_upper_out[2:0]) + 3'h1) &&
        (next_fetch_pointer_out == $past(target_in))) else $error("call pointer or target");
    AST_RET_PTR: assert property ($past(op_in) inside {SWFL_OP_RET, SWFL_OP_RET_EN} |->
        status_upper_out[2:0] == $past(status_upper_out[2:0]) - 3'h1) else $error("ret pointer");
    AST_CALL_RET: assert property ((op_in == SWFL_OP_CALL) ##1 (op_in == SWFL_OP_RET)
        |=> next_fetch_pointer_out == $past(return_addr_in, 2)) else $error("return address");
    AST_PRESET_LOWER: assert property ($past(op_in) == SWFL_OP_PRSL |->
        status_lower_out == ($past(status_lower_out) | $past(operand_in))) else $error("preset");
    AST_CLEAR_LOWER: assert property ($past(op_in) == SWFL_OP_CLSL |->
        status_lower_out == ($past(status_lower_out) & ~$past(operand_in))) else $error("clear");
    AST_LOAD_CC: assert property (($past(op_in) == SWFL_OP_LOAD) && !$past(reg_to_reg_in) |->
        status_lower_out[7:6] == (($past(operand_in) == 8'h00) ? 2'h0 :
        ($past(operand_in[7]) ? 2'h2 : 2'h1))) else $error("load condition");

    cover property ($rose(int_pending_out));
    cover property ((op_in == SWFL_OP_CALL) ##1 (op_in == SWFL_OP_RET));
    cover property (status_lower_out[7:6] == 2'h3);
endmodule

bind swfl_core swfl_core_monitor #(.ADDR_W(ADDR_W)) swfl_core_monitor_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .op_in(op_in), .reg_to_reg_in(reg_to_reg_in),
    .operand_in(operand_in), .target_in(target_in), .return_addr_in(return_addr_in),
    .sense_pin_in(sense_pin_in), .int_pending_out(int_pending_out),
    .status_upper_out(status_upper_out), .status_lower_out(status_lower_out),
    .next_fetch_pointer_out(next_fetch_pointer_out)
);

// ==== status_word_flag_logic_tb.sv ====
/*
 * Self-checking testbench for swfl_core: drives decoded operations and pins.
 * Assumes the checker is bound by its own file and a 4 ns clock.
 */
`timescale 1ns/1ps

module status_word_flag_logic_tb;
    import swfl_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    swfl_op_e op_in = SWFL_OP_NOP;
    logic [1:0] reg_num_in = 2'h0;
    logic reg_to_reg_in = 1'b0;
    logic [7:0] operand_in = 8'h00;
    logic [14:0] target_in = 15'h0000;
    logic [14:0] return_addr_in = 15'h0000;
    logic fetch_step_in = 1'b0;
    logic int_taken_in = 1'b0;
    logic sense_pin_in = 1'b0;
    logic int_req_n_in = 1'b1;
    logic flag_out, int_pending_out;
    logic [7:0] status_upper_out, status_lower_out, reg_data_out;
    logic [14:0] next_fetch_pointer_out;
    int bad_count = 0;
    int checked = 0;

    swfl_core swfl_core_inst (.clk_in(clk_in), .resetn_in(resetn_in), .op_in(op_in),
        .reg_num_in(reg_num_in), .reg_to_reg_in(reg_to_reg_in), .operand_in(operand_in),
        .target_in(target_in), .return_addr_in(return_addr_in), .fetch_step_in(fetch_step_in),
        .int_taken_in(int_taken_in), .sense_pin_in(sense_pin_in), .int_req_n_in(int_req_n_in),
        .flag_out(flag_out), .int_pending_out(int_pending_out),
        .status_upper_out(status_upper_out), .status_lower_out(status_lower_out),
        .reg_data_out(reg_data_out), .next_fetch_pointer_out(next_fetch_pointer_out));

    always #2 clk_in = ~clk_in;

    // ***************************************************
    // drivers and comparisons
    // ***************************************************
    // the op stays applied until the next call, so every scenario but t_lower and t_upper ends on a follow-up op
    task automatic op(input swfl_op_e o, input logic [1:0] rn, input logic [7:0] d);
        op_in = o;
        reg_num_in = rn;
        operand_in = d;
        @(posedge clk_in);
        #1;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_addr(input logic [14:0] got, input logic [14:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: address %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checked %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_lower();
        op(SWFL_OP_LOAD, 2'h0, 8'hC0);
        op(SWFL_OP_LDSL, 2'h0, 8'h00);
        chk_byte(status_lower_out, 8'hC0);
        op(SWFL_OP_CLSL, 2'h0, 8'h80);
        chk_byte(status_lower_out, 8'h40);
        op(SWFL_OP_PRSL, 2'h0, 8'h3F);
        chk_byte(status_lower_out, 8'h7F);
    endtask

    // bank 0 is forced by the clear so register one is always the same one
    task automatic arith(input logic [7:0] status_lower_byte, input swfl_op_e o, input logic [7:0] a,
                         input logic [7:0] b, input logic [7:0] sl, input logic [7:0] r);
        op(SWFL_OP_CLSL, 2'h0, 8'hFF);
        op(SWFL_OP_PRSL, 2'h0, status_lower_byte);
        op(SWFL_OP_LOAD, 2'h1, a);
        op(o, 2'h1, b);
        chk_byte(status_lower_out, sl);
        op(SWFL_OP_NOP, 2'h1, 8'h00);
        chk_byte(reg_data_out, r);
    endtask

    task automatic t_arith();
        arith(8'h00, SWFL_OP_ADD, 8'h7C, 8'h40, 8'h84, 8'hBC);
        arith(8'h09, SWFL_OP_ADD, 8'h0F, 8'h01, 8'h68, 8'h11);
        arith(8'h00, SWFL_OP_ADD, 8'hFF, 8'h01, 8'h21, 8'h00);
        arith(8'h00, SWFL_OP_SUB, 8'h80, 8'h01, 8'h45, 8'h7F);
        arith(8'h01, SWFL_OP_SUB, 8'h05, 8'h02, 8'h61, 8'h03);
        arith(8'h00, SWFL_OP_SUB, 8'h01, 8'h02, 8'h80, 8'hFF);
        arith(8'h08, SWFL_OP_SUB, 8'h05, 8'h02, 8'h69, 8'h02);
        arith(8'h00, SWFL_OP_CMP, 8'h80, 8'h01, 8'h80, 8'h80);
        arith(8'h02, SWFL_OP_CMP, 8'h80, 8'h01, 8'h42, 8'h80);
        arith(8'h00, SWFL_OP_CMP, 8'h33, 8'h33, 8'h00, 8'h33);
        arith(8'h00, SWFL_OP_TEST, 8'hF0, 8'h30, 8'h00, 8'hF0);
        arith(8'h00, SWFL_OP_TEST, 8'hF0, 8'h18, 8'h80, 8'hF0);
        arith(8'h01, SWFL_OP_ROL, 8'h81, 8'h00, 8'h41, 8'h03);
        arith(8'h08, SWFL_OP_ROL, 8'h40, 8'h00, 8'h8C, 8'h80);
        arith(8'h09, SWFL_OP_ROR, 8'h01, 8'h00, 8'h8D, 8'h80);
    endtask

    task automatic t_bank();
        op(SWFL_OP_CLSL, 2'h0, 8'hFF);
        op(SWFL_OP_LOAD, 2'h1, 8'h11);
        op(SWFL_OP_PRSL, 2'h0, 8'h10);
        op(SWFL_OP_LOAD, 2'h1, 8'h22);
        op(SWFL_OP_CLSL, 2'h0, 8'h10);
        op(SWFL_OP_NOP, 2'h1, 8'h00);
        chk_byte(reg_data_out, 8'h11);
    endtask

    task automatic t_upper();
        sense_pin_in = 1'b1;
        op(SWFL_OP_LOAD, 2'h0, 8'hFF);
        op(SWFL_OP_LDSU, 2'h0, 8'h00);
        repeat (2) op(SWFL_OP_NOP, 2'h0, 8'h00);
        chk_byte(status_upper_out, 8'hE7);
        chk_byte({7'h00, flag_out}, 8'h01);
        op(SWFL_OP_CLSU, 2'h0, 8'hFF);
        chk_byte(status_upper_out, 8'h80);
        op(SWFL_OP_PRSU, 2'h0, 8'h47);
        chk_byte(status_upper_out, 8'hC7);
        target_in = 15'h1234;
        return_addr_in = 15'h0111;
        op(SWFL_OP_CALL, 2'h0, 8'h00);
        chk_byte(status_upper_out, 8'hC0);
        chk_addr(next_fetch_pointer_out, 15'h1234);
        target_in = 15'h2000;
        return_addr_in = 15'h0222;
        op(SWFL_OP_CALL, 2'h0, 8'h00);
        op(SWFL_OP_RET, 2'h0, 8'h00);
        chk_addr(next_fetch_pointer_out, 15'h0222);
        op(SWFL_OP_RET, 2'h0, 8'h00);
        chk_addr(next_fetch_pointer_out, 15'h0111);
        chk_byte(status_upper_out, 8'hC7);
        sense_pin_in = 1'b0;
    endtask

    task automatic t_int();
        int n;
        op(SWFL_OP_CLSU, 2'h0, 8'hFF);
        int_req_n_in = 1'b0;
        n = 0;
        while (int_pending_out !== 1'b1 && n < 10) begin
            op(SWFL_OP_NOP, 2'h0, 8'h00);
            n++;
        end
        chk_byte({7'h00, status_upper_out[5]}, 8'h01);
        int_taken_in = 1'b1;
        op(SWFL_OP_NOP, 2'h0, 8'h00);
        int_taken_in = 1'b0;
        repeat (4) op(SWFL_OP_NOP, 2'h0, 8'h00);
        chk_byte({7'h00, int_pending_out}, 8'h00);
        int_req_n_in = 1'b1;
        repeat (4) op(SWFL_OP_NOP, 2'h0, 8'h00);
        op(SWFL_OP_RET_EN, 2'h0, 8'h00);
        chk_byte({7'h00, status_upper_out[5]}, 8'h00);
        op(SWFL_OP_NOP, 2'h0, 8'h00);
    endtask

    // reg-to-reg forms, logic ops, store and test of the lower byte, branch and step
    task automatic t_misc();
        op(SWFL_OP_CLSL, 2'h0, 8'hFF);
        op(SWFL_OP_LOAD, 2'h0, 8'h05);
        op(SWFL_OP_LOAD, 2'h1, 8'h09);
        reg_to_reg_in = 1'b1;
        op(SWFL_OP_CMP, 2'h1, 8'h00);
        chk_byte(status_lower_out, 8'h80);
        op(SWFL_OP_AND, 2'h1, 8'h00);
        reg_to_reg_in = 1'b0;
        op(SWFL_OP_IOR, 2'h0, 8'hF0);
        op(SWFL_OP_EOR, 2'h0, 8'h0F);
        op(SWFL_OP_STSL, 2'h0, 8'h00);
        chk_byte(reg_data_out, 8'hFE);
        op(SWFL_OP_TSSL, 2'h0, 8'h80);
        chk_byte(reg_data_out, 8'h80);
        chk_byte(status_lower_out, 8'h00);
        target_in = 15'h0100;
        op(SWFL_OP_BRANCH, 2'h0, 8'h00);
        fetch_step_in = 1'b1;
        op(SWFL_OP_NOP, 2'h0, 8'h00);
        fetch_step_in = 1'b0;
        chk_addr(next_fetch_pointer_out, 15'h0101);
    endtask

    initial begin
        #40000;
        bad_count++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        chk_addr(next_fetch_pointer_out, 15'h0000);
        chk_byte({7'h00, int_pending_out}, 8'h00);
        t_lower();
        t_arith();
        t_bank();
        t_upper();
        t_int();
        t_misc();
        summarize();
    end
endmodule
